/* File: include/wsn_regs.svh */
// Constants for the wiper step and nonvolatile map block
`ifndef WSN_REGS_SVH
`define WSN_REGS_SVH
`define WSN_CODE_W 10
`define WSN_WORD_W 16
`define WSN_NVM_DEPTH 16
`define WSN_FRAME_BITS 5'h18
`define WSN_CNT_MAX 5'h1F
`define WSN_CMD_MSB 23
`define WSN_CMD_LSB 20
`define WSN_ADDR_MSB 19
`define WSN_ADDR_LSB 16
`define WSN_SEL_BIT 16
`define WSN_CODE_ZERO 10'h000
`define WSN_CODE_ONE 10'h001
`define WSN_CODE_MID 10'h200
`define WSN_CODE_FULL 10'h3FF
`define WSN_ADDR_WIPER_ONE 4'h0
`define WSN_ADDR_WIPER_TWO 4'h1
`define WSN_ADDR_USER_FIRST 4'h2
`define WSN_ADDR_USER_LAST 4'hE
`define WSN_ADDR_TOLERANCE 4'hF
`define WSN_USER_WORDS 13
`define WSN_TOL_SIGN_BIT 15
`define WSN_TOL_INT_MSB 14
`define WSN_TOL_INT_LSB 8
`define WSN_TOL_FRAC_MSB 7
`define WSN_TOL_FRAC_LSB 0
`endif

/* File: include/wsn_pkg.sv */
// Types for the wiper step and nonvolatile map block
package wsn_pkg;
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_RESTORE = 4'h1,
    CMD_STORE_WIPER = 4'h2,
    CMD_STORE_WORD = 4'h3,
    CMD_LOG_DN_ONE = 4'h4,
    CMD_LOG_DN_ALL = 4'h5,
    CMD_LIN_DN_ONE = 4'h6,
    CMD_LIN_DN_ALL = 4'h7,
    CMD_RESET = 4'h8,
    CMD_READ_WORD = 4'h9,
    CMD_READ_WIPER = 4'hA,
    CMD_WRITE_WIPER = 4'hB,
    CMD_LOG_UP_ONE = 4'hC,
    CMD_LOG_UP_ALL = 4'hD,
    CMD_LIN_UP_ONE = 4'hE,
    CMD_LIN_UP_ALL = 4'hF
  } wsn_cmd_e;

  typedef enum logic [1:0] {
    PH_BOOT = 2'b00,
    PH_IDLE = 2'b01,
    PH_FRAME = 2'b11
  } wsn_phase_e;

  typedef struct packed {
    wsn_phase_e phase;
    logic [1:0][9:0] wiper;
    logic [15:0][15:0] nvm;
    logic [23:0] shift;
    logic [23:0] last;
    logic [4:0] cnt;
    logic seen;
    logic sclk;
    logic cs_n;
    logic restore_n;
    logic [1023:0] tap_one;
    logic [1023:0] tap_two;
  } wsn_state_s;
endpackage

/* File: hw/wsn_core.sv */
// Serial command interpreter for two wiper registers and the nonvolatile word map
//
// Function
// - Single increment command raises the addressed wiper by one, except at full scale.
// - Ganged increment command raises both wipers by one together.
// - Log increment commands, single or ganged, shift the wiper code left.
// - Log decrement commands, single or ganged, shift the wiper code right.
// - Log increment of code zero sets code one.
// - Log increment at or above midscale sets full scale.
// - Log increment at full scale leaves the code at maximum.
// - Between one and midscale, shift left; decrement shifts right with zero fill.
// - Log decrement of odd code truncates the low bit without rounding.
// - Chip select pulse with no clocks repeats the previous command.
// - Word zero keeps wiper one setting, word one keeps wiper two.
// - Words two to fourteen are thirteen freely writable user words.
// - Saved settings load both wipers at power-on, reset and pin; restore loads the addressed wiper only.
// - Word fifteen holds the tolerance and cannot be written.
// - Tolerance is sign bit, seven integer bits, eight fraction bits.
// - Exactly one of 1024 taps is on, chosen by the wiper code.
// - Linear decrement lowers by one but holds at zero.
// - Linear increment raises by one but holds at full scale.
// - Commands act only when chip select returns high.
`timescale 1ns/1ps
`include "wsn_regs.svh"

module wsn_core #(
  parameter logic [15:0] P_SAVED_ONE = 16'h0200, // Initial saved wiper one word
  parameter logic [15:0] P_SAVED_TWO = 16'h0200, // Initial saved wiper two word
  parameter logic [15:0] P_TOLERANCE = 16'h8000  // Factory tolerance word
) (
  input wire logic i_clk,               // 25 MHz clock
  input wire logic i_rstn,              // Asynchronous reset, active low
  input wire logic i_cs_n,              // Chip select, active low
  input wire logic i_sclk,              // Serial clock, sampled
  input wire logic i_sdi,               // Serial in
  input wire logic i_restore_n,         // Restore pin, active low
  output logic o_sdo,                   // Serial out
  output logic [9:0] o_wiper_one,       // Wiper one code
  output logic [9:0] o_wiper_two,       // Wiper two code
  output logic [1023:0] o_tap_one,      // Wiper one tap switches
  output logic [1023:0] o_tap_two       // Wiper two tap switches
);

  localparam logic [15:0][15:0] NVM_INIT = {P_TOLERANCE, {`WSN_USER_WORDS{16'h0000}},
                                            P_SAVED_TWO, P_SAVED_ONE};

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Code arithmetic
  // ----------------------------------------------------------------
  function automatic logic [9:0] log_up(input logic [9:0] c);
    if (c == `WSN_CODE_ZERO) begin
      log_up = `WSN_CODE_ONE;
    end else if (c >= `WSN_CODE_MID) begin
      log_up = `WSN_CODE_FULL;
    end else begin
      log_up = {c[8:0], 1'b0};
    end
  endfunction

  function automatic logic [9:0] log_dn(input logic [9:0] c);
    log_dn = {1'b0, c[9:1]};
  endfunction

  function automatic logic [9:0] lin_up(input logic [9:0] c);
    lin_up = (c == `WSN_CODE_FULL) ? c : 10'(c + `WSN_CODE_ONE);
  endfunction

  function automatic logic [9:0] lin_dn(input logic [9:0] c);
    lin_dn = (c == `WSN_CODE_ZERO) ? c : 10'(c - `WSN_CODE_ONE);
  endfunction

  function automatic logic [1023:0] one_hot(input logic [9:0] c);
    one_hot = 1024'h1 << c;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  wsn_pkg::wsn_state_s q;
  wsn_pkg::wsn_state_s d;
  logic exec_w;
  logic [23:0] word_w;
  logic restore_w;

  always_comb begin
    logic [3:0] cmd;
    logic [3:0] addr;
    logic sel;
    cmd = 4'h0;
    addr = 4'h0;
    sel = 1'b0;
    d = q;
    d.sclk = i_sclk;
    d.cs_n = i_cs_n;
    d.restore_n = i_restore_n;
    exec_w = 1'b0;
    restore_w = 1'b0;
    word_w = q.last;
    unique case (q.phase)
      wsn_pkg::PH_BOOT: begin
        restore_w = 1'b1;
        d.phase = wsn_pkg::PH_IDLE;
      end
      wsn_pkg::PH_IDLE: begin
        if (!i_cs_n && q.cs_n) begin
          d.cnt = 5'h00;
          d.seen = 1'b0;
          d.phase = wsn_pkg::PH_FRAME;
        end else if (!i_restore_n && q.restore_n) begin
          restore_w = 1'b1;
        end
      end
      wsn_pkg::PH_FRAME: begin
        if (i_sclk && !q.sclk) begin
          d.shift = {q.shift[22:0], i_sdi};
          d.seen = 1'b1;
          if (q.cnt != `WSN_CNT_MAX) begin
            d.cnt = 5'(q.cnt + 5'h01);
          end
        end
        if (i_cs_n) begin
          d.phase = wsn_pkg::PH_IDLE;
          exec_w = !q.seen || (q.cnt == `WSN_FRAME_BITS);
          word_w = q.seen ? q.shift : q.last;
        end
      end
      default: begin
        d.phase = wsn_pkg::PH_IDLE;
      end
    endcase

    if (restore_w) begin
      d.wiper[0] = q.nvm[`WSN_ADDR_WIPER_ONE][9:0];
      d.wiper[1] = q.nvm[`WSN_ADDR_WIPER_TWO][9:0];
    end

    if (exec_w) begin
      cmd = word_w[`WSN_CMD_MSB:`WSN_CMD_LSB];
      addr = word_w[`WSN_ADDR_MSB:`WSN_ADDR_LSB];
      sel = word_w[`WSN_SEL_BIT];
      d.last = word_w;
      unique case (cmd)
        wsn_pkg::CMD_RESTORE: d.wiper[sel] = q.nvm[{3'h0, sel}][9:0];
        wsn_pkg::CMD_STORE_WIPER: d.nvm[{3'h0, sel}] = {6'h00, q.wiper[sel]};
        wsn_pkg::CMD_STORE_WORD: begin
          if (addr != `WSN_ADDR_TOLERANCE) begin
            d.nvm[addr] = word_w[15:0];
          end
        end
        wsn_pkg::CMD_LOG_DN_ONE: d.wiper[sel] = log_dn(q.wiper[sel]);
        wsn_pkg::CMD_LOG_DN_ALL: begin
          d.wiper[0] = log_dn(q.wiper[0]);
          d.wiper[1] = log_dn(q.wiper[1]);
        end
        wsn_pkg::CMD_LIN_DN_ONE: d.wiper[sel] = lin_dn(q.wiper[sel]);
        wsn_pkg::CMD_LIN_DN_ALL: begin
          d.wiper[0] = lin_dn(q.wiper[0]);
          d.wiper[1] = lin_dn(q.wiper[1]);
        end
        wsn_pkg::CMD_RESET: begin
          d.wiper[0] = q.nvm[`WSN_ADDR_WIPER_ONE][9:0];
          d.wiper[1] = q.nvm[`WSN_ADDR_WIPER_TWO][9:0];
        end
        wsn_pkg::CMD_READ_WORD: d.shift = {word_w[23:16], q.nvm[addr]};
        wsn_pkg::CMD_READ_WIPER: d.shift = {word_w[23:16], 6'h00, q.wiper[sel]};
        wsn_pkg::CMD_WRITE_WIPER: d.wiper[sel] = word_w[9:0];
        wsn_pkg::CMD_LOG_UP_ONE: d.wiper[sel] = log_up(q.wiper[sel]);
        wsn_pkg::CMD_LOG_UP_ALL: begin
          d.wiper[0] = log_up(q.wiper[0]);
          d.wiper[1] = log_up(q.wiper[1]);
        end
        wsn_pkg::CMD_LIN_UP_ONE: d.wiper[sel] = lin_up(q.wiper[sel]);
        wsn_pkg::CMD_LIN_UP_ALL: begin
          d.wiper[0] = lin_up(q.wiper[0]);
          d.wiper[1] = lin_up(q.wiper[1]);
        end
        wsn_pkg::CMD_NOP: begin
        end
      endcase
    end

    d.tap_one = one_hot(d.wiper[0]);
    d.tap_two = one_hot(d.wiper[1]);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      q <= '0;
      q.phase <= wsn_pkg::PH_BOOT;
      q.nvm <= NVM_INIT;
      q.cs_n <= 1'b1;
      q.restore_n <= 1'b1;
      q.tap_one <= 1024'h1;
      q.tap_two <= 1024'h1;
    end else begin
      q <= d;
    end
  end

  assign o_sdo = q.shift[23];
  assign o_wiper_one = q.wiper[0];
  assign o_wiper_two = q.wiper[1];
  assign o_tap_one = q.tap_one;
  assign o_tap_two = q.tap_two;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  inc_one_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    exec_w && word_w[23:20] == wsn_pkg::CMD_LIN_UP_ONE && !word_w[16]
      && q.wiper[0] != `WSN_CODE_FULL
    |=> q.wiper[0] == 10'($past(q.wiper[0]) + 10'h001))
    else $error("single increment did not add one");

  inc_all_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    exec_w && word_w[23:20] == wsn_pkg::CMD_LIN_UP_ALL
      && q.wiper[0] != `WSN_CODE_FULL && q.wiper[1] != `WSN_CODE_FULL
    |=> q.wiper[1] == 10'($past(q.wiper[1]) + 10'h001)
      && q.wiper[0] == 10'($past(q.wiper[0]) + 10'h001))
    else $error("ganged increment did not move both wipers");

  log_up_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    exec_w && word_w[23:20] == wsn_pkg::CMD_LOG_UP_ONE && word_w[16]
      && q.wiper[1] != `WSN_CODE_ZERO && q.wiper[1] < `WSN_CODE_MID
    |=> q.wiper[1] == {$past(q.wiper[1][8:0]), 1'b0})
    else $error("log increment did not shift left");

  log_dn_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    exec_w && word_w[23:20] == wsn_pkg::CMD_LOG_DN_ALL
    |=> q.wiper[0] == {1'b0, $past(q.wiper[0][9:1])}
      && q.wiper[1] == {1'b0, $past(q.wiper[1][9:1])})
    else $error("log decrement did not shift right");

  log_zero_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    exec_w && word_w[23:20] == wsn_pkg::CMD_LOG_UP_ALL && q.wiper[0] == `WSN_CODE_ZERO
    |=> q.wiper[0] == `WSN_CODE_ONE)
    else $error("log increment from zero did not give one");

  log_sat_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    exec_w && word_w[23:20] == wsn_pkg::CMD_LOG_UP_ONE && !word_w[16]
      && q.wiper[0] >= `WSN_CODE_MID
    |=> q.wiper[0] == `WSN_CODE_FULL)
    else $error("log increment at midscale did not saturate");

  lin_floor_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    exec_w && word_w[23:20] == wsn_pkg::CMD_LIN_DN_ALL && q.wiper[1] == `WSN_CODE_ZERO
    |=> q.wiper[1] == `WSN_CODE_ZERO)
    else $error("linear decrement went below zero");

  tol_fixed_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    q.nvm[`WSN_ADDR_TOLERANCE] == P_TOLERANCE)
    else $error("tolerance word was overwritten");

  tap_onehot_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    $onehot(q.tap_one) && q.tap_two == one_hot(q.wiper[1]))
    else $error("tap switches not one-hot on the wiper code");

  frame_quiet_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    q.phase == wsn_pkg::PH_FRAME && !i_cs_n |=> $stable(q.wiper) && $stable(q.nvm))
    else $error("state changed while bits were shifting");

  repeat_cmd_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    q.phase == wsn_pkg::PH_FRAME && i_cs_n && !q.seen
    |-> exec_w && word_w == q.last ##1 q.last == $past(q.last))
    else $error("bare select did not repeat the previous command");

  restore_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    q.phase == wsn_pkg::PH_IDLE && !i_restore_n && q.restore_n && i_cs_n
    |=> q.wiper[0] == $past(q.nvm[`WSN_ADDR_WIPER_ONE][9:0])
      && q.wiper[1] == $past(q.nvm[`WSN_ADDR_WIPER_TWO][9:0]))
    else $error("restore pin did not load saved settings");

  boot_load_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    q.phase == wsn_pkg::PH_BOOT
    |=> q.wiper[0] == $past(q.nvm[`WSN_ADDR_WIPER_ONE][9:0])
      && q.wiper[1] == $past(q.nvm[`WSN_ADDR_WIPER_TWO][9:0]))
    else $error("power-on did not load saved settings");

  odd_trunc_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    exec_w && word_w[`WSN_CMD_MSB:`WSN_CMD_LSB] == wsn_pkg::CMD_LOG_DN_ONE
      && !word_w[`WSN_SEL_BIT] && q.wiper[0][0]
    |=> q.wiper[0] == {1'b0, $past(q.wiper[0][9:1])})
    else $error("log decrement of odd code did not truncate");

  lin_ceil_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    exec_w && word_w[`WSN_CMD_MSB:`WSN_CMD_LSB] == wsn_pkg::CMD_LIN_UP_ONE
      && word_w[`WSN_SEL_BIT] && q.wiper[1] == `WSN_CODE_FULL
    |=> q.wiper[1] == `WSN_CODE_FULL)
    else $error("linear increment went past full scale");

  user_store_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
    exec_w && word_w[`WSN_CMD_MSB:`WSN_CMD_LSB] == wsn_pkg::CMD_STORE_WORD
      && word_w[`WSN_ADDR_MSB:`WSN_ADDR_LSB] != `WSN_ADDR_TOLERANCE
    |=> q.nvm[$past(word_w[`WSN_ADDR_MSB:`WSN_ADDR_LSB])] == $past(word_w[15:0]))
    else $error("user word was not stored");

endmodule

/* File: verification/wsn_host.sv */
// Host model driving the serial command port and the restore pin
`timescale 1ns/1ps
module wsn_host (
  input wire logic i_clk,     // System clock
  input wire logic i_sdo,     // Serial out of the device
  output logic o_cs_n,        // Chip select, active low
  output logic o_sclk,        // Serial clock, still outside frames
  output logic o_sdi,         // Serial in
  output logic o_restore_n,   // Restore pin, active low
  output logic o_done,        // One-cycle pulse once outputs settled
  output logic [23:0] o_rx    // Word seen on serial out
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    o_restore_n = 1'b1;
    o_done = 1'b0;
    o_rx = 24'h000000;
  end

  // Data line flips once released so a stale level is never mistaken
  task automatic finish_op(input int n);
    repeat (n) @(negedge i_clk);
    o_done = 1'b1;
    o_sdi = ~o_sdi;
    @(negedge i_clk);
    o_done = 1'b0;
  endtask

  task automatic frame(input logic [23:0] w, input int n = 24);
    @(negedge i_clk);
    o_cs_n = 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      @(negedge i_clk);
      o_sclk = 1'b0;
      o_sdi = w[i];
      o_rx[i] = i_sdo;
      @(negedge i_clk);
      o_sclk = 1'b1;
    end
    @(negedge i_clk);
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    finish_op(1);
  endtask

  task automatic strobe();
    @(negedge i_clk);
    o_cs_n = 1'b0;
    @(negedge i_clk);
    o_cs_n = 1'b1;
    finish_op(1);
  endtask

  task automatic restore();
    @(negedge i_clk);
    o_restore_n = 1'b0;
    finish_op(2);
    o_restore_n = 1'b1;
  endtask
endmodule

/* File: verification/wiper_step_and_nvm_map_bench.sv */
// Self-checking bench for the wiper step and nonvolatile map block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module wiper_step_and_nvm_map_bench;
  typedef struct packed {
    logic [9:0] w1;
    logic [9:0] w2;
    logic [23:0] rx;
    logic chk_rx;
  } wsn_note_s;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cs_n, sclk, serial_in, restore_n, serial_out, done;
  logic [23:0] rx;
  logic [9:0] w1, w2;
  logic [1023:0] tap1, tap2;
  wsn_note_s notes[$];
  wsn_note_s nt;
  logic [9:0] m [2];
  logic [15:0] mn [16];
  logic [23:0] sr, last;
  logic sr_ok = 1'b0;
  int miscompares = 0;
  int num_checks = 0;

  always #20 clk = ~clk;

  wsn_core #(.P_SAVED_ONE(16'h0155), .P_SAVED_TWO(16'h0003), .P_TOLERANCE(16'h9C0F)) wsn_core_i (
    .i_clk(clk), .i_rstn(rstn), .i_cs_n(cs_n), .i_sclk(sclk), .i_sdi(serial_in),
    .i_restore_n(restore_n), .o_sdo(serial_out), .o_wiper_one(w1), .o_wiper_two(w2),
    .o_tap_one(tap1), .o_tap_two(tap2));
  wsn_host wsn_host_i (.i_clk(clk), .i_sdo(serial_out), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(serial_in),
    .o_restore_n(restore_n), .o_done(done), .o_rx(rx));

  function automatic logic [9:0] up6(input logic [9:0] v);
    if (v == 10'h000) return 10'h001;
    if (v >= 10'h200) return 10'h3FF;
    return v << 1;
  endfunction

  // Expected effect of one command on the reference copy
  task automatic model(input logic [23:0] w, input logic rep);
    logic [3:0] c;
    logic [3:0] a;
    c = w[23:20];
    a = w[19:16];
    case (c)
      4'h1: m[a[0]] = mn[a[0]][9:0];
      4'h2: mn[a[0]] = {6'h00, m[a[0]]};
      4'h3: if (a != 4'hF) mn[a] = w[15:0];
      4'h4: m[a[0]] = m[a[0]] >> 1;
      4'h5: for (int i = 0; i < 2; i++) m[i] = m[i] >> 1;
      4'h6: m[a[0]] = (m[a[0]] == 10'h000) ? 10'h000 : m[a[0]] - 10'h001;
      4'h7: for (int i = 0; i < 2; i++) m[i] = (m[i] == 10'h000) ? 10'h000 : m[i] - 10'h001;
      4'h8: for (int i = 0; i < 2; i++) m[i] = mn[i][9:0];
      4'hB: m[a[0]] = w[9:0];
      4'hC: m[a[0]] = up6(m[a[0]]);
      4'hD: for (int i = 0; i < 2; i++) m[i] = up6(m[i]);
      4'hE: m[a[0]] = (m[a[0]] == 10'h3FF) ? 10'h3FF : m[a[0]] + 10'h001;
      4'hF: for (int i = 0; i < 2; i++) m[i] = (m[i] == 10'h3FF) ? 10'h3FF : m[i] + 10'h001;
      default: ;
    endcase
    if (!rep) sr = w;
    if (c == 4'h9) sr = {w[23:16], mn[a]};
    if (c == 4'hA) sr = {w[23:16], 6'h00, m[a[0]]};
  endtask

  task automatic send(input logic [23:0] w);
    logic [23:0] prev;
    logic ok;
    prev = sr;
    ok = sr_ok;
    model(w, 1'b0);
    notes.push_back({m[0], m[1], prev, ok});
    sr_ok = 1'b1;
    last = w;
    wsn_host_i.frame(w);
  endtask

  task automatic again();
    model(last, 1'b1);
    notes.push_back({m[0], m[1], 24'h000000, 1'b0});
    wsn_host_i.strobe();
  endtask

  // Short frame: nothing runs and the serial word is no longer predictable
  task automatic runt(input logic [23:0] w);
    notes.push_back({m[0], m[1], 24'h000000, 1'b0});
    sr_ok = 1'b0;
    wsn_host_i.frame(w, 23);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk) begin
    if (done === 1'b1) begin
      nt = notes.pop_front();
      `CHK("wiper one", nt.w1, w1)
      `CHK("wiper two", nt.w2, w2)
      `CHK("tap one", 1024'h1 << nt.w1, tap1)
      `CHK("tap two", 1024'h1 << nt.w2, tap2)
      if (nt.chk_rx) `CHK("serial out", nt.rx, rx)
    end
  end

  initial begin
    #(40 * 60000);
    miscompares++;
    report_and_stop();
  end

  initial begin
    logic [23:0] seq [$];
    logic [31:0] r;
    logic [3:0] c, a;
    void'($urandom(32'h0C42E63C));
    m[0] = 10'h155;
    m[1] = 10'h003;
    mn[0] = 16'h0155;
    mn[1] = 16'h0003;
    mn[15] = 16'h9C0F;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    `CHK("boot wiper one", 10'h155, w1)
    `CHK("boot wiper two", 10'h003, w2)
    notes.push_back({m[0], m[1], 24'h000000, 1'b0});
    wsn_host_i.restore();
    for (int i = 2; i < 15; i++) send({4'h3, 4'(i), 16'($urandom)});
    send(24'hB00000);
    repeat (12) send(24'hC00000);
    repeat (11) send(24'h400000);
    seq = {24'h600000, 24'hD00000, 24'hB103FF, 24'hE10000, 24'hE00000};
    foreach (seq[i]) send(seq[i]);
    runt(24'hB003FF);
    again();
    seq = {24'hD00000, 24'h500000, 24'h700000, 24'hF00000, 24'h9F0000, 24'h3FFFFF,
      24'h9F0000, 24'h200000, 24'h900000, 24'hB00123, 24'h800000, 24'hC10000,
      24'hB00077, 24'hB10000, 24'h700000, 24'h100000, 24'hA10000};
    foreach (seq[i]) send(seq[i]);
    again();
    notes.push_back({mn[0][9:0], mn[1][9:0], 24'h000000, 1'b0});
    m[0] = mn[0][9:0];
    m[1] = mn[1][9:0];
    wsn_host_i.restore();
    for (int i = 0; i < 150; i++) begin
      r = $urandom;
      c = r[23:20];
      a = (c == 4'h3 || c == 4'h9) ? r[19:16] : {3'b000, r[16]};
      if (c == 4'h8) a = 4'h0;
      send({c, a, r[15:0]});
      if (r[31:29] == 3'b000) again();
    end
    send(24'h000000);
    repeat (4) @(negedge clk);
    `CHK("pending notes", 0, notes.size())
    report_and_stop();
  end
endmodule
